// ---- hw/aifs_pkg.sv ----
package aifs_pkg;
  localparam int CH_N = 6;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int AL_N = 5;
  // channel condition word bit positions
  localparam int ST_HH = 0;
  localparam int ST_LL = 1;
  localparam int ST_H = 2;
  localparam int ST_L = 3;
  localparam int ST_RATE = 4;
  localparam int ST_OVR = 5;
  localparam int ST_UND = 6;
  localparam int ST_CAL = 7;
  // module summary word bit positions
  localparam int MW_AG = 15;
  localparam int MW_IG = 14;
  localparam int MW_CALIB = 12;
  localparam int MW_CALF = 11;
  localparam logic [15:0] CHF_CAL = 16'h003f;
  localparam logic [15:0] CHF_COMM = 16'hffff;
  localparam int INT_UND_TOP = 15;
  localparam int INT_OVR_TOP = 14;
  // register indices
  localparam logic [AW-1:0] A_CTRL = 4'h0;
  localparam logic [AW-1:0] A_UNLATCH = 4'h1;
  localparam logic [AW-1:0] A_MOD = 4'h2;
  localparam logic [AW-1:0] A_CHF = 4'h3;
  localparam logic [AW-1:0] A_INT = 4'h4;
  localparam logic [AW-1:0] A_ST0 = 4'h8;
  localparam int CTRL_INT = 0;
  localparam int CTRL_LAT_LSB = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [DW-1:0] value;
  } aifs_sample_t;

  typedef struct packed {
    logic [DW-1:0] hh;
    logic [DW-1:0] hi;
    logic [DW-1:0] lo;
    logic [DW-1:0] ll;
    logic [DW-1:0] dband;
    logic [DW-1:0] rate;
    logic [DW-1:0] span_min;
    logic [DW-1:0] span_max;
  } aifs_limits_t;

  typedef struct packed {
    logic [15:0] mod_w;
    logic [15:0] chf_w;
    logic [15:0] int_w;
    logic [CH_N-1:0][7:0] st;
  } aifs_words_t;

  typedef struct packed {
    logic [CH_N-1:0][7:0] status;
    logic [CH_N-1:0][AL_N-1:0] rel;
    logic [CH_N-1:0][DW-1:0] prev;
    logic [CH_N-1:0] seen;
    logic int_mode;
    logic [CH_N-1:0] latch;
    aifs_words_t words;
    logic upd;
    logic [15:0] rdata;
  } aifs_state_t;
endpackage : aifs_pkg

// ---- hw/aifs_status.sv ----
// Notes on behaviour
// (R1) float mode: channel at or below span minimum sets bit 6 and fault bit
// (R2) float mode: channel at or above span maximum sets bit 5 and fault bit
// (R3) failed calibration sets bit 7 and module calibration fault bit 11
// (R4) rate alarm bit 4 sets above rate limit, clears below it if unlatched
// (R5) low alarm bit 3 sets below low limit, clears above trigger point
// (R6) high alarm bit 2 sets above high limit, clears below trigger point
// (R7) low-low alarm bit 1 sets below low-low limit, clears above it
// (R8) high-high alarm bit 0 sets above high-high limit, clears below it
// (R9) set process alarm holds while input stays within the deadband
// (R10) latched alarm holds until the controller issues an unlatch
// (R11) module word: bit 15, 14, 12, 11 used; 13, 10, 9, 8 zero
// (R12) both group fault bits follow any set channel fault bit
// (R13) any channel calibrating sets bit 12 and, without a comm fault, forces channel word 003f
// (R14) owner communication fault forces channel fault word to ffff
// (R15) channel fault bits 0 to 5 map to channels 0 to 5
// (R16) integer mode: one shared word, range flags only, no alarms
// (R17) integer word: underrange at 15-2n, overrange at 14-2n
// (R18) integer mode range flags also set the channel fault bit
// (R19) integer mode still reports module calibration fault
// (R20) words go out together with each channel data update
// (R21) bits evaluated per sample; summaries registered, derived from the new channel bits and the calibration and comm inputs
// (R22) unlatch clears only once the alarm condition is gone
`timescale 1ns/1ps
module aifs_status
  import aifs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire aifs_sample_t i_smp,
  input wire aifs_limits_t i_lim,
  input wire logic [CH_N-1:0] i_cal_active,
  input wire logic [CH_N-1:0] i_cal_fail,
  input wire logic i_comm_fault,
  input wire logic [AW-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output aifs_words_t o_words,
  output logic o_update,
  output logic [15:0] o_rdata
);
  // refuse, while elaborating, sizes that the fixed word layouts cannot hold
  if (CH_N < 1 || CH_N > 6 || DW < 2) begin : g_bad_size
    $error("aifs_status: unsupported channel count or width");
  end

  aifs_state_t s_reg;
  aifs_state_t s_next;
  logic [CH_N-1:0] unl_mask;
  logic [CH_N-1:0][7:0] st_nx;
  logic [CH_N-1:0][AL_N-1:0] rel_nx;

  assign unl_mask = (i_wr && i_addr == A_UNLATCH) ?
                    i_wdata[CH_N-1:0] : '0;

  function automatic logic signed [DW+1:0] sx(input logic [DW-1:0] a);
    sx = {{2{a[DW-1]}}, a};
  endfunction : sx

  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    logic hit;
    logic signed [DW+1:0] v;
    logic signed [DW+1:0] diff;
    logic [DW+1:0] mag;
    logic [AL_N-1:0] set5;
    logic [AL_N-1:0] rel5;
    logic [AL_N-1:0] gone;
    logic [AL_N-1:0] clr;
    logic [AL_N-1:0] alm;
    logic und;
    logic ovr;

    assign hit = i_smp.valid && i_smp.chan == 3'(c);
    assign v = sx(i_smp.value);
    assign diff = v - sx(s_reg.prev[c]);
    assign mag = diff[DW+1] ? $unsigned(-diff) : $unsigned(diff);

    always_comb begin
      set5 = '0;
      rel5 = '1;
      set5[ST_HH] = v > sx(i_lim.hh); // see (R8)
      set5[ST_LL] = v < sx(i_lim.ll); // see (R7)
      set5[ST_H] = v > sx(i_lim.hi); // see (R6)
      set5[ST_L] = v < sx(i_lim.lo); // see (R5)
      // release only once past the limit by the deadband
      rel5[ST_HH] = v < sx(i_lim.hh) - sx(i_lim.dband); // see (R9)
      rel5[ST_LL] = v > sx(i_lim.ll) + sx(i_lim.dband); // see (R9)
      rel5[ST_H] = v < sx(i_lim.hi) - sx(i_lim.dband); // see (R9)
      rel5[ST_L] = v > sx(i_lim.lo) + sx(i_lim.dband); // see (R9)
      // no rate on a channel's first sample: there is nothing to compare
      if (s_reg.seen[c]) begin
        set5[ST_RATE] = mag > {2'b00, i_lim.rate}; // see (R4)
        rel5[ST_RATE] = mag < {2'b00, i_lim.rate}; // see (R4)
      end else begin
        set5[ST_RATE] = 1'b0;
      end
    end

    assign gone = hit ? rel5 : s_reg.rel[c];
    // unlatch only drops alarms whose condition has gone, see (R22)
    assign clr = (hit && !s_reg.latch[c] ? rel5 : '0) |
                 (unl_mask[c] && s_reg.latch[c] ? gone : '0); // see (R10)
    // a new sample that sets wins over any clear in the same cycle
    assign alm = s_reg.int_mode ? '0 :
                 (s_reg.status[c][AL_N-1:0] & ~clr) |
                 (hit ? set5 : '0); // see (R16)
    assign und = hit ? v <= sx(i_lim.span_min) :
                 s_reg.status[c][ST_UND]; // see (R1) (R18)
    assign ovr = hit ? v >= sx(i_lim.span_max) :
                 s_reg.status[c][ST_OVR]; // see (R2) (R18)
    assign st_nx[c] = {i_cal_fail[c] && !s_reg.int_mode, und, ovr,
                       alm}; // see (R3) (R21)
    assign rel_nx[c] = hit ? rel5 : s_reg.rel[c];
  end

  always_comb begin
    s_next = s_reg;
    s_next.upd = i_smp.valid; // see (R20)
    if (i_wr && i_addr == A_CTRL) begin
      s_next.int_mode = i_wdata[CTRL_INT];
      s_next.latch = i_wdata[CTRL_LAT_LSB +: CH_N];
    end
    s_next.status = st_nx;
    s_next.rel = rel_nx;
    for (int c = 0; c < CH_N; c++) begin
      if (i_smp.valid && i_smp.chan == 3'(c)) begin
        s_next.prev[c] = i_smp.value;
        s_next.seen[c] = 1'b1;
      end
    end
    // output words, derived from the new channel bits and the calibration and comm inputs
    s_next.words = '0;
    for (int c = 0; c < CH_N; c++) begin
      s_next.words.chf_w[c] = st_nx[c][ST_UND] |
                              st_nx[c][ST_OVR]; // see (R15)
      if (s_reg.int_mode) begin
        s_next.words.int_w[INT_UND_TOP-2*c] =
          st_nx[c][ST_UND]; // see (R17)
        s_next.words.int_w[INT_OVR_TOP-2*c] =
          st_nx[c][ST_OVR]; // see (R17)
      end else begin
        s_next.words.st[c] = st_nx[c];
      end
    end
    if (i_comm_fault) begin
      s_next.words.chf_w = CHF_COMM; // see (R14)
    end else if (|i_cal_active) begin
      s_next.words.chf_w = CHF_CAL; // see (R13)
    end
    s_next.words.mod_w[MW_AG] = |s_next.words.chf_w; // see (R12)
    s_next.words.mod_w[MW_IG] = |s_next.words.chf_w; // see (R12)
    s_next.words.mod_w[MW_CALIB] = |i_cal_active; // see (R13) (R11)
    s_next.words.mod_w[MW_CALF] = |i_cal_fail; // see (R3) (R19) (R11)
    s_next.rdata = '0;
    if (i_rd) begin
      if (i_addr == A_CTRL) begin
        s_next.rdata[CTRL_INT] = s_reg.int_mode;
        s_next.rdata[CTRL_LAT_LSB +: CH_N] = s_reg.latch;
      end else if (i_addr == A_MOD) begin
        s_next.rdata = s_reg.words.mod_w;
      end else if (i_addr == A_CHF) begin
        s_next.rdata = s_reg.words.chf_w;
      end else if (i_addr == A_INT) begin
        s_next.rdata = s_reg.words.int_w;
      end else if (i_addr >= A_ST0 && i_addr < A_ST0 + AW'(CH_N)) begin
        s_next.rdata = {8'h00, s_reg.words.st[3'(i_addr - A_ST0)]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '0;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  assign o_words = s_reg.words;
  assign o_update = s_reg.upd;
  assign o_rdata = s_reg.rdata;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic quiet;
  assign quiet = i_ce && !i_wr && !i_comm_fault && !(|i_cal_active);

  a_comm_word: assert property ( // see (R14)
    i_ce && i_comm_fault |=> o_words.chf_w == CHF_COMM)
    else $error("channel word not ffff under comm fault");
  a_calib_word: assert property ( // see (R13)
    i_ce && !i_comm_fault && |i_cal_active |=>
    o_words.chf_w == CHF_CAL && o_words.mod_w[MW_CALIB])
    else $error("calibrating not reported");
  a_group_bits: assert property ( // see (R12)
    o_words.mod_w[MW_AG] == (|o_words.chf_w) &&
    o_words.mod_w[MW_IG] == (|o_words.chf_w))
    else $error("group fault bits disagree with channel word");
  a_unused_bits: assert property ( // see (R11)
    o_words.mod_w[13] == 1'b0 && o_words.mod_w[10:0] == '0)
    else $error("unused module word bit set");
  a_float_under: assert property ( // see (R1)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd0 &&
    $signed(i_smp.value) <= $signed(i_lim.span_min) |=>
    o_words.st[0][ST_UND] && o_words.chf_w[0])
    else $error("underrange not flagged");
  a_float_over: assert property ( // see (R2)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd1 &&
    $signed(i_smp.value) >= $signed(i_lim.span_max) |=>
    o_words.st[1][ST_OVR] && o_words.chf_w[1])
    else $error("overrange not flagged");
  a_int_layout: assert property ( // see (R17)
    quiet && s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd5 &&
    $signed(i_smp.value) >= $signed(i_lim.span_max) |=>
    o_words.int_w[4] && o_words.chf_w[5] && o_words.st[5] == '0)
    else $error("integer word layout wrong");
  a_cal_summary: assert property ( // see (R3)
    i_ce && |i_cal_fail |=> o_words.mod_w[MW_CALF])
    else $error("calibration fault summary missing");
  a_low_alarm: assert property ( // see (R5)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd2 &&
    $signed(i_smp.value) < $signed(i_lim.lo) |=> o_words.st[2][ST_L])
    else $error("low alarm not set");
  a_latch_hold: assert property ( // see (R10)
    quiet && !s_reg.int_mode && s_reg.latch[0] &&
    s_reg.status[0][ST_HH] && !i_smp.valid |=> s_reg.status[0][ST_HH])
    else $error("latched alarm dropped without unlatch");
  a_update_pulse: assert property ( // see (R20)
    i_ce && i_smp.valid |=> o_update)
    else $error("update not sent with sample");

  a_float_calerr: assert property ( // see (R3)
    i_ce && !i_wr && !s_reg.int_mode && i_cal_fail[0] |=>
    o_words.st[0][ST_CAL])
    else $error("channel calibration error bit not set");

  a_int_no_status: assert property ( // see (R16)
    i_ce && !i_wr && s_reg.int_mode |=> o_words.st == '0)
    else $error("channel condition word nonzero in integer mode");

  a_float_no_int: assert property ( // see (R16)
    i_ce && !i_wr && !s_reg.int_mode |=> o_words.int_w == '0)
    else $error("integer range word nonzero in float mode");

  a_high_alarm: assert property ( // see (R6)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd4 &&
    $signed(i_smp.value) > $signed(i_lim.hi) |=> o_words.st[4][ST_H])
    else $error("high alarm not set");

  a_hh_alarm: assert property ( // see (R8)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd4 &&
    $signed(i_smp.value) > $signed(i_lim.hh) |=> o_words.st[4][ST_HH])
    else $error("high-high alarm not set");

  a_ll_alarm: assert property ( // see (R7)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd1 &&
    $signed(i_smp.value) < $signed(i_lim.ll) |=> o_words.st[1][ST_LL])
    else $error("low-low alarm not set");

  a_rate_alarm: assert property ( // see (R4)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd0 &&
    g_ch[0].set5[ST_RATE] |=> o_words.st[0][ST_RATE])
    else $error("rate alarm not set");

  a_deadband_hold: assert property ( // see (R9)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd4 &&
    s_reg.status[4][ST_H] && !g_ch[4].rel5[ST_H] |=>
    o_words.st[4][ST_H])
    else $error("alarm dropped inside deadband");

  a_low_clear: assert property ( // see (R5)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd1 &&
    !s_reg.latch[1] && g_ch[1].rel5[ST_L] &&
    !g_ch[1].set5[ST_L] |=> !o_words.st[1][ST_L])
    else $error("unlatched low alarm did not clear");

  a_hh_clear: assert property ( // see (R8)
    quiet && !s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd4 &&
    !s_reg.latch[4] && g_ch[4].rel5[ST_HH] &&
    !g_ch[4].set5[ST_HH] |=> !o_words.st[4][ST_HH])
    else $error("unlatched high-high alarm did not clear");

  a_unlatch_keep: assert property ( // see (R22)
    i_ce && i_wr && i_addr == A_UNLATCH && i_wdata[3] &&
    !s_reg.int_mode && s_reg.latch[3] && s_reg.status[3][ST_H] &&
    !g_ch[3].gone[ST_H] |=> s_reg.status[3][ST_H])
    else $error("unlatch cleared an alarm whose condition stands");

  a_unlatch_clear: assert property ( // see (R10)
    i_ce && i_wr && i_addr == A_UNLATCH && i_wdata[3] &&
    !s_reg.int_mode && s_reg.latch[3] && s_reg.status[3][ST_H] &&
    g_ch[3].gone[ST_H] && !g_ch[3].hit |=> !s_reg.status[3][ST_H])
    else $error("unlatch did not clear a released alarm");

  a_int_under: assert property ( // see (R17) (R18)
    quiet && s_reg.int_mode && i_smp.valid && i_smp.chan == 3'd0 &&
    $signed(i_smp.value) <= $signed(i_lim.span_min) |=>
    o_words.int_w[INT_UND_TOP] && o_words.chf_w[0])
    else $error("integer underrange layout wrong");

  a_update_idle: assert property ( // see (R20)
    i_ce && !i_smp.valid |=> !o_update)
    else $error("update without a sample");

  a_calf_clear: assert property ( // see (R19)
    i_ce && i_cal_fail == '0 |=> !o_words.mod_w[MW_CALF])
    else $error("calibration fault summary without a failure");

  a_chan_map: assert property ( // see (R15)
    quiet && !s_reg.int_mode |=>
    o_words.chf_w[0] == (o_words.st[0][ST_UND] | o_words.st[0][ST_OVR]))
    else $error("channel fault bit does not follow range bits");

  a_chf_upper: assert property ( // see (R15)
    quiet |=> o_words.chf_w[15:CH_N] == '0)
    else $error("channel fault word upper bits set");

  // a low enable must hold every output, read data included
  a_ce_freeze: assert property ( // see (R21)
    !i_ce |=> $stable(o_words) && $stable(o_rdata) && $stable(o_update))
    else $error("state moved with clock enable low");

  c_dband: cover property (
    i_smp.valid && s_reg.status[4][ST_H] && !g_ch[4].rel5[ST_H]);
  c_comm: cover property (i_ce && i_comm_fault ##1 o_update);
  c_calib: cover property (i_ce && |i_cal_active ##1 o_words.mod_w[12]);
  c_unlatch: cover property (
    s_reg.latch[0] && s_reg.status[0][ST_H] ##1 !s_reg.status[0][ST_H]);
  c_int_mode: cover property (s_reg.int_mode && o_words.int_w != '0);
endmodule : aifs_status

// ---- tb/aifs_owner_model.sv ----
`timescale 1ns/1ps
module aifs_owner_model
  import aifs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_update,
  input wire aifs_words_t i_words,
  output logic [15:0] o_upd_cnt,
  output aifs_words_t o_last
);
  // the owner only trusts words that arrive with an update pulse
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_upd_cnt <= 16'h0000;
      o_last <= '0;
    end else if (i_update) begin
      o_upd_cnt <= o_upd_cnt + 16'h0001;
      o_last <= i_words;
    end
  end
endmodule : aifs_owner_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import aifs_pkg::*;
  typedef struct {int sel; logic [15:0] e;} aifs_note_t;
  logic i_clk, i_rst_b, i_ce, i_wr, i_rd, i_comm_fault, rd_d, o_update;
  aifs_sample_t i_smp;
  aifs_limits_t i_lim;
  logic [CH_N-1:0] i_cal_active, i_cal_fail;
  logic [AW-1:0] i_addr;
  logic [15:0] i_wdata, o_rdata, upd_cnt;
  aifs_words_t o_words;
  int errors, samples_checked, n_smp;
  logic [31:0] seed = 32'h99ef;
  aifs_note_t q[$];
  aifs_note_t nt;

  aifs_status aifs_status_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_ce(i_ce), .i_smp(i_smp), .i_lim(i_lim),
    .i_cal_active(i_cal_active), .i_cal_fail(i_cal_fail),
    .i_comm_fault(i_comm_fault), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_words(o_words), .o_update(o_update),
    .o_rdata(o_rdata));
  aifs_owner_model aifs_owner_model_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_update(o_update), .i_words(o_words), .o_upd_cnt(upd_cnt),
    .o_last());

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [15:0] pick(int sel);
    if (sel == 0) return o_words.mod_w;
    if (sel == 1) return o_words.chf_w;
    if (sel == 2) return o_words.int_w;
    if (sel == 9) return o_rdata;
    return {8'h00, o_words.st[sel-3]};
  endfunction : pick

  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // results are only settled a cycle after the request, so notes queue up
  always @(posedge i_clk) begin
    rd_d <= i_rd && i_ce;
    if (rd_d || o_update) begin
      if (q.size() == 0) begin
        errors++;
        $display("wrong value note exp queued seen none");
      end else begin
        nt = q.pop_front();
        check($sformatf("word %0d", nt.sel), pick(nt.sel), nt.e);
      end
    end
  end

  task automatic smp(logic [2:0] c, logic [15:0] v, int sel, logic [15:0] e);
    q.push_back('{sel, e});
    @(posedge i_clk);
    i_smp <= '{1'b1, c, v};
    n_smp++;
    @(posedge i_clk);
    i_smp.valid <= 1'b0;
    @(posedge i_clk);
  endtask : smp

  // channel 7 maps to no channel but still refreshes the words
  task automatic chk(int sel, logic [15:0] e);
    smp(3'h7, 16'h0000, sel, e);
  endtask : chk

  task automatic wr(logic [AW-1:0] a, logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [AW-1:0] a, logic [15:0] e);
    q.push_back('{9, e});
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    wrap_up();
  end

  initial begin
    logic [2:0] c;
    logic [15:0] v;
    {i_rst_b, i_wr, i_rd, i_comm_fault, rd_d} = '0;
    {i_cal_active, i_cal_fail, i_addr, i_wdata} = '0;
    i_ce = 1'b1;
    i_smp = '0;
    i_lim = '{16'h03e8, 16'h01f4, 16'hfe0c, 16'hfc18, 16'h000a,
      16'hffff, 16'hf830, 16'h07d0};
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(A_CTRL, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      c = 3'(xs() % 6);
      v = 16'(int'(xs() % 801) - 400);
      smp(c, v, 3 + int'(c), 16'h0000);
    end
    smp(3'h2, 16'hf448, 5, 16'h004a);
    chk(1, 16'h0004);
    smp(3'h5, 16'h0bb8, 8, 16'h0025);
    chk(0, 16'hc000);
    rd(A_ST0 + 4'h2, 16'h004a);
    smp(3'h2, 16'h0000, 5, 16'h0000);
    smp(3'h5, 16'h0000, 8, 16'h0000);
    chk(0, 16'h0000);
    smp(3'h1, 16'hfda8, 4, 16'h0008);
    smp(3'h1, 16'hfbb4, 4, 16'h000a);
    smp(3'h4, 16'h044c, 7, 16'h0005);
    smp(3'h4, 16'h0258, 7, 16'h0004);
    smp(3'h4, 16'h01ef, 7, 16'h0004);
    smp(3'h4, 16'h01e0, 7, 16'h0000);
    smp(3'h0, 16'h0000, 3, 16'h0000);
    @(posedge i_clk);
    i_lim.rate <= 16'h0064;
    smp(3'h0, 16'h012c, 3, 16'h0010);
    smp(3'h0, 16'h0136, 3, 16'h0000);
    i_lim.rate <= 16'hffff;
    wr(A_CTRL, 16'h0800);
    smp(3'h3, 16'h0258, 6, 16'h0004);
    smp(3'h3, 16'h0000, 6, 16'h0004);
    wr(A_UNLATCH, 16'h0008);
    chk(6, 16'h0000);
    smp(3'h3, 16'h0258, 6, 16'h0004);
    wr(A_UNLATCH, 16'h0008);
    chk(6, 16'h0004);
    wr(A_CTRL, 16'h0001);
    smp(3'h0, 16'hf448, 2, 16'h8000);
    smp(3'h5, 16'h0bb8, 2, 16'h8010);
    chk(3, 16'h0000);
    chk(1, 16'h0021);
    rd(A_INT, 16'h8010);
    i_cal_fail <= 6'h04;
    chk(0, 16'hc800);
    i_cal_active <= 6'h02;
    chk(1, 16'h003f);
    chk(0, 16'hd800);
    i_comm_fault <= 1'b1;
    chk(1, 16'hffff);
    wr(A_MOD, 16'h1234);
    rd(A_MOD, 16'hd800);
    rd(4'hf, 16'h0000);
    for (int k = 0; k < 20 && q.size() > 0; k++) @(posedge i_clk);
    if (q.size() > 0) errors++;
    check("updates", upd_cnt, n_smp[15:0]);
    wrap_up();
  end
endmodule : testbench
